// ===== shared/ep_state_consts.vh
// Command codes, status bit positions and reset values for the endpoint state block
`ifndef EP_STATE_CONSTS_VH
`define EP_STATE_CONSTS_VH

`define OP_STALL        4'h4
`define OP_RD_STATUS    4'h5
`define OP_VALIDATE     4'h6
`define OP_CLEAR        4'h7
`define OP_UNSTALL      4'h8
`define OP_CHECK        4'hd
`define CMD_ACK_SETUP   8'hf4

`define IDX_CTRL_OUT    4'h0
`define IDX_CTRL_IN     4'h1

`define BIT_HALT        7
`define BIT_FULL2       6
`define BIT_FULL1       5
`define BIT_TOGGLE      4
`define BIT_CLOBBER     3
`define BIT_SETUP       2
`define BIT_HOST_CPU_BUFFER_SELECT      1

`define STATE_RESET     8'h00
`define NUM_EP          16
`define ONE_HOT_LSB     16'h0001
`define CTRL_EP_MASK    16'h0003
`define NO_EP           16'h0000
`define FLAG_RESET      1'b0

`endif

// ===== design/ep_state_cmd.v
// Endpoint state registers and command decoder
`timescale 1ns/1ps
`include "ep_state_consts.vh"

module ep_state_cmd #(
    parameter NUM_EP = `NUM_EP
) (
    input  wire        clk,
    input  wire        reset,
    input  wire        cmd_valid,
    input  wire [7:0]  cmd_code,
    input  wire        rd_strobe,
    output reg  [7:0]  rd_data,
    output reg  [15:0] ep_irq_clear,
    input  wire [15:0] ep_is_in,
    input  wire [15:0] ep_double_buf,
    input  wire        sie_setup_token,
    input  wire        sie_setup_done,
    input  wire [3:0]  sie_ep,
    input  wire        sie_pkt_ok,
    input  wire        sie_in_sent,
    output wire [15:0] ep_nak,
    output wire [15:0] ep_halted
);

// ----------------------------------------
// Per-endpoint state
// ----------------------------------------
wire [NUM_EP-1:0]   halt_w;
wire [NUM_EP-1:0]   full1_w;
wire [NUM_EP-1:0]   full2_w;
wire [NUM_EP-1:0]   toggle_w;
wire [NUM_EP-1:0]   clobber_w;
wire [NUM_EP-1:0]   setup_w;
wire [NUM_EP-1:0]   host_cpu_buffer_select_w;
wire [NUM_EP-1:0]   sie_buf_w;
wire [NUM_EP-1:0]   setup_busy_w;
wire [NUM_EP-1:0]   nak_w;
wire [NUM_EP*8-1:0] endpoint_state_byte;
wire [NUM_EP*8-1:0] endpoint_state_shadow;
reg                 setup_lock_r;
reg                 setup_lock_nxt;
reg  [7:0]          rd_data_nxt;
reg  [15:0]         ep_irq_clear_nxt;

// ----------------------------------------
// Command decode
// ----------------------------------------
wire [3:0]  op;
wire [3:0]  idx;
wire [15:0] sel;
wire        is_ctrl;
wire        dir_in;
wire        ctrl_locked;
wire        do_stall;
wire        do_unstall;
wire        do_validate;
wire        do_clear;
wire        do_rd;
wire        do_check;
wire        do_ack;
wire [15:0] sie_sel;
wire [15:0] setup_ev;
wire [7:0]  live_byte;
wire [7:0]  image_byte;

assign op          = cmd_code[7:4];
assign idx         = cmd_code[3:0];
assign sel         = `ONE_HOT_LSB << idx;
assign is_ctrl     = (idx == `IDX_CTRL_OUT) || (idx == `IDX_CTRL_IN);
assign dir_in      = ep_is_in[idx];
assign ctrl_locked = is_ctrl && setup_lock_r;

assign do_stall    = cmd_valid && (op == `OP_STALL);
assign do_unstall  = cmd_valid && (op == `OP_UNSTALL);
assign do_validate = cmd_valid && (op == `OP_VALIDATE) && (idx != `IDX_CTRL_OUT)
                     && dir_in && !ctrl_locked;
assign do_clear    = cmd_valid && (op == `OP_CLEAR) && (idx != `IDX_CTRL_IN)
                     && !dir_in && !ctrl_locked;
assign do_rd       = cmd_valid && (op == `OP_RD_STATUS);
assign do_check    = cmd_valid && (op == `OP_CHECK);
assign do_ack      = cmd_valid && (cmd_code == `CMD_ACK_SETUP);

assign sie_sel  = `ONE_HOT_LSB << sie_ep;
assign setup_ev = sie_setup_token ? (`CTRL_EP_MASK & sie_sel) : `NO_EP;

// ----------------------------------------
// Port outputs
// ----------------------------------------
assign ep_halted = halt_w;
assign ep_nak    = nak_w;

// ----------------------------------------
// Read data and interrupt clear
// ----------------------------------------
assign live_byte  = endpoint_state_byte[{idx, 3'b000} +: 8];
assign image_byte = endpoint_state_shadow[{idx, 3'b000} +: 8];

always @* begin
    rd_data_nxt      = rd_data;
    ep_irq_clear_nxt = `NO_EP;
    if (do_rd) begin
        rd_data_nxt      = live_byte;
        ep_irq_clear_nxt = sel;
    end else if (do_check) begin
        rd_data_nxt = image_byte;
    end
end

// ----------------------------------------
// Setup lock
// ----------------------------------------
always @* begin
    setup_lock_nxt = setup_lock_r;
    if (do_ack)
        setup_lock_nxt = 1'b0;
    if (sie_setup_token)
        setup_lock_nxt = 1'b1;
end

// ----------------------------------------
// Shared registers
// ----------------------------------------
always @(posedge clk) begin
    if (reset) begin
        setup_lock_r <= `FLAG_RESET;
        rd_data      <= `STATE_RESET;
        ep_irq_clear <= `NO_EP;
    end else begin
        setup_lock_r <= setup_lock_nxt;
        rd_data      <= rd_data_nxt;
        ep_irq_clear <= ep_irq_clear_nxt;
    end
end

// ----------------------------------------
// Endpoint slots
// ----------------------------------------
genvar g;
generate
    for (g = 0; g < NUM_EP; g = g + 1) begin : ep_slot
        reg       halt_r;
        reg       halt_nxt;
        reg       full1_r;
        reg       full1_nxt;
        reg       full2_r;
        reg       full2_nxt;
        reg       toggle_r;
        reg       toggle_nxt;
        reg       clobber_r;
        reg       clobber_nxt;
        reg       setup_r;
        reg       setup_nxt;
        reg       host_cpu_buffer_select_r;
        reg       host_cpu_buffer_select_nxt;
        reg       sie_buf_r;
        reg       sie_buf_nxt;
        reg       busy_r;
        reg       busy_nxt;
        reg [7:0] state_byte;
        reg [7:0] shadow_r;

        wire      cmd_hit;
        wire      sie_hit;
        wire      setup_hit;
        wire      leave_halt;
        wire      pkt_move;

        assign cmd_hit    = sel[g];
        assign sie_hit    = sie_sel[g];
        assign setup_hit  = setup_ev[g];
        assign leave_halt = (do_unstall && cmd_hit) || (setup_hit && halt_r);
        assign pkt_move   = (sie_pkt_ok || sie_in_sent) && sie_hit && !halt_r;

        // ------------------------------------
        // Next state
        // ------------------------------------
        always @* begin
            halt_nxt    = halt_r;
            full1_nxt   = full1_r;
            full2_nxt   = full2_r;
            toggle_nxt  = toggle_r;
            clobber_nxt = clobber_r;
            setup_nxt   = setup_r;
            host_cpu_buffer_select_nxt  = host_cpu_buffer_select_r;
            sie_buf_nxt = sie_buf_r;
            busy_nxt    = busy_r;

            if (do_stall && cmd_hit)
                halt_nxt = 1'b1;

            // Leaving stall clears halt, both full flags, toggle and both buffer selects; setup and clobber flags keep their value
            if (leave_halt) begin
                halt_nxt    = 1'b0;
                full1_nxt   = 1'b0;
                full2_nxt   = 1'b0;
                toggle_nxt  = 1'b0;
                host_cpu_buffer_select_nxt  = 1'b0;
                sie_buf_nxt = 1'b0;
            end

            if (do_validate && cmd_hit) begin
                if (host_cpu_buffer_select_r)
                    full2_nxt = 1'b1;
                else
                    full1_nxt = 1'b1;
                if (ep_double_buf[g])
                    host_cpu_buffer_select_nxt = ~host_cpu_buffer_select_r;
            end

            if (do_clear && cmd_hit) begin
                if (host_cpu_buffer_select_r)
                    full2_nxt = 1'b0;
                else
                    full1_nxt = 1'b0;
                setup_nxt = 1'b0;
                if (ep_double_buf[g])
                    host_cpu_buffer_select_nxt = ~host_cpu_buffer_select_r;
            end

            // Good OUT packet or sent IN packet
            if (pkt_move) begin
                toggle_nxt = ~toggle_r;
                if (sie_pkt_ok && !ep_is_in[g]) begin
                    if (sie_buf_r)
                        full2_nxt = 1'b1;
                    else
                        full1_nxt = 1'b1;
                end
                if (sie_in_sent && ep_is_in[g]) begin
                    if (sie_buf_r)
                        full2_nxt = 1'b0;
                    else
                        full1_nxt = 1'b0;
                end
                if (ep_double_buf[g])
                    sie_buf_nxt = ~sie_buf_r;
            end

            if (setup_hit) begin
                setup_nxt  = (g == `IDX_CTRL_OUT);
                busy_nxt   = 1'b1;
                toggle_nxt = 1'b1;
                if (setup_lock_r)
                    clobber_nxt = 1'b1;
                if (g == `IDX_CTRL_OUT)
                    full1_nxt = 1'b1;
            end else if (sie_setup_done && sie_hit) begin
                busy_nxt = 1'b0;
            end

            // Setup_clobbered_flag flag survives a read while setup data is still landing
            if (do_rd && cmd_hit && !busy_r && !setup_hit)
                clobber_nxt = 1'b0;
        end

        // ------------------------------------
        // Status byte
        // ------------------------------------
        always @* begin
            state_byte = `STATE_RESET;
            state_byte[`BIT_HALT]    = halt_r;
            state_byte[`BIT_FULL2]   = full2_r;
            state_byte[`BIT_FULL1]   = full1_r;
            state_byte[`BIT_TOGGLE]  = toggle_r;
            state_byte[`BIT_CLOBBER] = clobber_r;
            state_byte[`BIT_SETUP]   = setup_r;
            state_byte[`BIT_HOST_CPU_BUFFER_SELECT]  = host_cpu_buffer_select_r;
        end

        // ------------------------------------
        // Registers
        // ------------------------------------
        always @(posedge clk) begin
            if (reset) begin
                halt_r    <= `FLAG_RESET;
                full1_r   <= `FLAG_RESET;
                full2_r   <= `FLAG_RESET;
                toggle_r  <= `FLAG_RESET;
                clobber_r <= `FLAG_RESET;
                setup_r   <= `FLAG_RESET;
                host_cpu_buffer_select_r  <= `FLAG_RESET;
                sie_buf_r <= `FLAG_RESET;
                busy_r    <= `FLAG_RESET;
                shadow_r  <= `STATE_RESET;
            end else begin
                halt_r    <= halt_nxt;
                full1_r   <= full1_nxt;
                full2_r   <= full2_nxt;
                toggle_r  <= toggle_nxt;
                clobber_r <= clobber_nxt;
                setup_r   <= setup_nxt;
                host_cpu_buffer_select_r  <= host_cpu_buffer_select_nxt;
                sie_buf_r <= sie_buf_nxt;
                busy_r    <= busy_nxt;
                shadow_r  <= state_byte;
            end
        end

        // ------------------------------------
        // Exports
        // ------------------------------------
        assign halt_w[g]       = halt_r;
        assign full1_w[g]      = full1_r;
        assign full2_w[g]      = full2_r;
        assign toggle_w[g]     = toggle_r;
        assign clobber_w[g]    = clobber_r;
        assign setup_w[g]      = setup_r;
        assign host_cpu_buffer_select_w[g]     = host_cpu_buffer_select_r;
        assign sie_buf_w[g]    = sie_buf_r;
        assign setup_busy_w[g] = busy_r;

        // OUT endpoint refuses while its current receive buffer is full
        assign nak_w[g] = !ep_is_in[g] && (sie_buf_r ? full2_r : full1_r);

        assign endpoint_state_byte[g*8 +: 8]   = state_byte;
        assign endpoint_state_shadow[g*8 +: 8] = shadow_r;
    end
endgenerate

endmodule // ep_state_cmd

// ===== testbench/ep_state_assertions.sv
// Port assertions for the endpoint state block
`timescale 1ns/1ps
module ep_state_assertions (
    input wire        clk,
    input wire        reset,
    input wire        cmd_valid,
    input wire [7:0]  cmd_code,
    input wire [7:0]  rd_data,
    input wire [15:0] ep_irq_clear,
    input wire        sie_setup_token,
    input wire [3:0]  sie_ep,
    input wire [15:0] ep_halted
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire [3:0] op = cmd_valid ? cmd_code[7:4] : 4'h0;
    wire [3:0] ix = cmd_code[3:0];
    sequence s_rd; op == 4'h5; endsequence
    a_read_irq: assert property (s_rd |=> ep_irq_clear == 16'h1 << $past(ix))
        else $error("irq clear wrong");
    a_irq_quiet: assert property (!(op == 4'h5) |=> ep_irq_clear == 16'h0)
        else $error("irq clear stray");
    a_rsvd_bit: assert property (s_rd |=> !rd_data[0])
        else $error("bit0 set");
    a_rd_hold: assert property (op != 4'h5 && op != 4'hd |=> $stable(rd_data))
        else $error("read data moved");
    a_stall_set: assert property (op == 4'h4 && !sie_setup_token |=> ep_halted[$past(ix)])
        else $error("stall lost");
    a_unstall_clr: assert property (op == 4'h8 |=> !ep_halted[$past(ix)])
        else $error("unstall lost");
    a_setup_unstall: assert property (sie_setup_token && sie_ep < 4'h2
        |=> !ep_halted[$past(sie_ep)]) else $error("setup kept halt");
    a_halt_hold: assert property (op == 4'h0 && !sie_setup_token |=> $stable(ep_halted))
        else $error("halt moved");
endmodule // ep_state_assertions

bind ep_state_cmd ep_state_assertions chk (.clk, .reset, .cmd_valid, .cmd_code, .rd_data,
    .ep_irq_clear, .sie_setup_token, .sie_ep, .ep_halted);

// ===== testbench/fw_cmd_model.sv
// Firmware model issuing endpoint command bytes
`timescale 1ns/1ps
module fw_cmd_model (
    input  wire       clk,
    output reg        cmd_valid = 1'b0,
    output reg  [7:0] cmd_code = 8'h00
);
    task cmd(input [7:0] c);
        begin
            @(posedge clk) #1 cmd_valid = 1'b1;
            cmd_code = c;
            @(posedge clk) #1 cmd_valid = 1'b0;
            cmd_code = ~c;
        end
    endtask
endmodule // fw_cmd_model

// ===== testbench/testbench.sv
// Self-checking bench for the endpoint state block
`timescale 1ns/1ps
module testbench;
    reg         clk = 1'b0;
    reg         reset = 1'b1;
    reg  [3:0]  ev = 4'h0;
    reg  [3:0]  ev_ep = 4'h0;
    wire        cmd_valid;
    wire [7:0]  cmd_code;
    wire [7:0]  rd_data;
    wire [15:0] ep_nak;
    wire [15:0] ep_halted;
    reg  [15:0] ep_dir = 16'h000a;
    reg  [15:0] ep_dbl = 16'h0008;
    reg         rd_stb = 1'b0;
    wire [15:0] irq_clr;
    integer     n_fail = 0;
    integer     num_checks = 0;
    integer     i;
    always #20 clk = ~clk;
    fw_cmd_model fw (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code));
    ep_state_cmd uut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .rd_strobe(rd_stb), .rd_data(rd_data), .ep_irq_clear(irq_clr), .ep_is_in(ep_dir),
        .ep_double_buf(ep_dbl), .sie_setup_token(ev[3]), .sie_setup_done(ev[2]),
        .sie_ep(ev_ep), .sie_pkt_ok(ev[1]), .sie_in_sent(ev[0]), .ep_nak(ep_nak),
        .ep_halted(ep_halted));
    task chk(input [47:0] nm, input [15:0] e, input [15:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task st(input [7:0] c, input [7:0] e);
        begin
            fw.cmd(c);
            rd_stb = 1'b1;
            chk("status", e, rd_data);
            chk("irqclr", (c[7:4] == 4'h5) ? (16'h1 << c[3:0]) : 16'h0, irq_clr);
            @(posedge clk) #1 rd_stb = 1'b0;
            chk("irqoff", 16'h0, irq_clr);
            chk("held", e, rd_data);
        end
    endtask
    task sie(input [3:0] k, input [3:0] ep);
        begin
            @(posedge clk) #1 ev = k;
            ev_ep = ep;
            @(posedge clk) #1 ev = 4'h0;
            ev_ep = ~ep;
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d failures %0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 reset = 1'b0;
        st(8'h5f, 8'h00);
        for (i = 0; i < 16; i = i + 1) begin
            fw.cmd({4'h4, i[3:0]});
            st({4'hd, i[3:0]}, 8'h80);
            fw.cmd({4'h8, i[3:0]});
            st({4'h5, i[3:0]}, 8'h00);
        end
        $display("test done: stall");
        fw.cmd(8'h63);
        st(8'h53, 8'h22);
        fw.cmd(8'h63);
        st(8'hd3, 8'h60);
        fw.cmd(8'h62);
        st(8'h52, 8'h00);
        sie(4'h2, 4'h2);
        chk("nak", 8'h01, {7'h0, ep_nak[2]});
        st(8'h52, 8'h30);
        fw.cmd(8'h72);
        st(8'h52, 8'h10);
        fw.cmd(8'h61);
        st(8'h51, 8'h20);
        ep_dir = 16'h001a;
        ep_dbl = 16'h0018;
        fw.cmd(8'h64);
        fw.cmd(8'h64);
        st(8'hd4, 8'h60);
        $display("test done: buffers");
        sie(4'h8, 4'h0);
        sie(4'h8, 4'h0);
        sie(4'h4, 4'h0);
        fw.cmd(8'h70);
        st(8'h50, 8'h3c);
        st(8'h50, 8'h34);
        fw.cmd(8'hf4);
        fw.cmd(8'h70);
        st(8'h50, 8'h10);
        fw.cmd(8'h40);
        sie(4'h8, 4'h0);
        chk("halt", 8'h00, {7'h0, ep_halted[0]});
        $display("test done: setup");
        end_of_test;
    end
endmodule // testbench
